// *** src/ccsd_pkg.sv ***
// shared constants, types and decode helpers of the spi command decoder
package ccsd_pkg;

	typedef logic [7:0] ccsd_byte_t;

	// command opcodes and the masks that strip their selector bits
	localparam ccsd_byte_t OP_RESET = 8'hC0;
	localparam ccsd_byte_t OP_READ = 8'h03;
	localparam ccsd_byte_t OP_WRITE = 8'h02;
	localparam ccsd_byte_t OP_MODIFY = 8'h05;
	localparam ccsd_byte_t OP_RD_STATUS = 8'hA0;
	localparam ccsd_byte_t OP_RX_STATUS = 8'hB0;
	localparam ccsd_byte_t OP_FAST_RD = 8'h90;
	localparam ccsd_byte_t OP_FAST_RD_MASK = 8'hF9;
	localparam ccsd_byte_t OP_LOAD_TX = 8'h40;
	localparam ccsd_byte_t OP_LOAD_TX_MASK = 8'hF8;
	localparam ccsd_byte_t OP_RTS = 8'h80;
	localparam ccsd_byte_t OP_RTS_MASK = 8'hF8;

	// last bit index of a serial byte
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam ccsd_byte_t MASK_ALL = 8'hFF;
	localparam ccsd_byte_t PTR_STEP = 8'h01;

	// fast-access start locations of the receive and transmit buffers
	localparam ccsd_byte_t RX0_ID_ADDR = 8'h61;
	localparam ccsd_byte_t RX0_DATA_ADDR = 8'h66;
	localparam ccsd_byte_t RX1_ID_ADDR = 8'h71;
	localparam ccsd_byte_t RX1_DATA_ADDR = 8'h76;
	localparam ccsd_byte_t TX0_ID_ADDR = 8'h31;
	localparam ccsd_byte_t TX1_ID_ADDR = 8'h41;
	localparam ccsd_byte_t TX2_ID_ADDR = 8'h51;
	localparam ccsd_byte_t TX_DATA_OFS = 8'h05;
	localparam logic [1:0] TX_SEL_BAD = 2'h3;

	// registers that accept a masked update
	localparam ccsd_byte_t BM_PIN_CTRL = 8'h0C;
	localparam ccsd_byte_t BM_RTS_CTRL = 8'h0D;
	localparam ccsd_byte_t BM_CFG_LO = 8'h28;
	localparam ccsd_byte_t BM_CFG_HI = 8'h2D;
	localparam logic [3:0] BM_MODE_LOW = 4'hF;
	localparam logic [3:0] BM_BUF_LOW = 4'h0;
	localparam logic [3:0] BM_BUF_HI_MIN = 4'h3;
	localparam logic [3:0] BM_BUF_HI_MAX = 4'h7;

	// receive-status byte field positions
	localparam int RXS_PEND1 = 7;
	localparam int RXS_PEND0 = 6;
	localparam int RXS_EXT = 4;
	localparam int RXS_RTR = 3;
	localparam int RXS_FILT_LSB = 0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_RD = 3'b010,
		ST_WR = 3'b011,
		ST_BM_MASK = 3'b100,
		ST_BM_DATA = 3'b101,
		ST_STAT = 3'b110,
		ST_IGNORE = 3'b111
	} ccsd_state_e;

	// one access to the register file
	typedef struct packed {
		ccsd_byte_t addr;
		ccsd_byte_t wdata;
		ccsd_byte_t wmask;
		logic wr;
	} ccsd_reg_req_s;

	// state of the received frame for the receive-status byte
	typedef struct packed {
		logic [1:0] receive_pending_flag;
		logic ext;
		logic rtr;
		logic [2:0] filt;
	} ccsd_rx_info_s;

	function automatic ccsd_byte_t fast_rd_addr(input logic buf_sel, input logic data_sel);
		unique case ({buf_sel, data_sel})
			2'b00: fast_rd_addr = RX0_ID_ADDR;
			2'b01: fast_rd_addr = RX0_DATA_ADDR;
			2'b10: fast_rd_addr = RX1_ID_ADDR;
			2'b11: fast_rd_addr = RX1_DATA_ADDR;
		endcase
	endfunction

	function automatic ccsd_byte_t load_tx_addr(input logic [1:0] buf_sel, input logic data_sel);
		ccsd_byte_t base;
		base = (buf_sel == 2'h0) ? TX0_ID_ADDR : (buf_sel == 2'h1) ? TX1_ID_ADDR : TX2_ID_ADDR;
		load_tx_addr = data_sel ? 8'(base + TX_DATA_OFS) : base;
	endfunction

	function automatic logic bm_capable(input ccsd_byte_t a);
		bm_capable = (a == BM_PIN_CTRL) || (a == BM_RTS_CTRL) || (a[3:0] == BM_MODE_LOW) ||
			((a >= BM_CFG_LO) && (a <= BM_CFG_HI)) ||
			((a[3:0] == BM_BUF_LOW) && (a[7:4] >= BM_BUF_HI_MIN) && (a[7:4] <= BM_BUF_HI_MAX));
	endfunction

	function automatic ccsd_byte_t rx_status_byte(input ccsd_rx_info_s i);
		ccsd_byte_t b;
		b = 8'h00;
		b[RXS_PEND1] = i.receive_pending_flag[1];
		b[RXS_PEND0] = i.receive_pending_flag[0];
		b[RXS_EXT] = i.ext;
		b[RXS_RTR] = i.rtr;
		b[RXS_FILT_LSB +: 3] = i.filt;
		rx_status_byte = b;
	endfunction

endpackage

// *** src/ccsd_spi_rx.sv ***
// serial input shifter with clock edge detection and byte framing
`timescale 1ns/100ps
module ccsd_spi_rx (
	input wire logic clk,
	input wire logic rst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	output ccsd_pkg::ccsd_byte_t rx_byte,
	output logic byte_done,
	output logic sck_fall
);
	import ccsd_pkg::*;

	typedef struct packed {
		logic sck_q;
		logic [2:0] cnt;
		ccsd_byte_t sh;
		ccsd_byte_t data;
		logic done;
		logic fall;
	} ccsd_rx_s;

	ccsd_rx_s s;
	ccsd_rx_s next_s;

	// sample on rising sck, flag falling sck, restart framing while deselected
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		next_s.fall = 1'b0;
		next_s.sck_q = sck;
		if (cs_n) begin
			next_s.cnt = 3'h0; // a partial byte is dropped here
		end else begin
			if (sck && !s.sck_q) begin
				next_s.sh = {s.sh[6:0], si};
				next_s.cnt = 3'(s.cnt + 3'h1);
				if (s.cnt == BIT_LAST) begin
					next_s.data = {s.sh[6:0], si};
					next_s.done = 1'b1;
				end
			end
			if (!sck && s.sck_q) begin
				next_s.fall = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rx_byte = s.data;
	assign byte_done = s.done;
	assign sck_fall = s.fall;
endmodule // ccsd_spi_rx

// *** src/ccsd_spi_tx.sv ***
// serial output shifter that changes its bit on falling sck
`timescale 1ns/100ps
module ccsd_spi_tx (
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic sck_fall,
	input wire logic load,
	input wire ccsd_pkg::ccsd_byte_t ld_data,
	output logic so,
	output logic so_oe
);
	import ccsd_pkg::*;

	typedef struct packed {
		ccsd_byte_t sh;
		logic so;
		logic oe;
	} ccsd_tx_s;

	ccsd_tx_s s;
	ccsd_tx_s next_s;
	ccsd_byte_t base;

	// a load and a falling edge in one cycle still emit the new msb
	always_comb begin
		next_s = s;
		next_s.oe = !cs_n;
		base = load ? ld_data : s.sh;
		if (cs_n) begin
			next_s.sh = 8'h00;
			next_s.so = 1'b0;
		end else if (sck_fall) begin
			next_s.so = base[7];
			next_s.sh = {base[6:0], 1'b0};
		end else begin
			next_s.sh = base;
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign so = s.so;
	assign so_oe = s.oe;
endmodule // ccsd_spi_tx

// *** src/ccsd_spi_cmd_decoder.sv ***
// spi command interpreter driving register file, transmit requests and flag clears
`timescale 1ns/100ps
module ccsd_spi_cmd_decoder (
	input wire logic clk,
	input wire logic rst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe,
	output ccsd_pkg::ccsd_reg_req_s reg_req,
	input wire ccsd_pkg::ccsd_byte_t reg_rd_data,
	input wire ccsd_pkg::ccsd_byte_t read_status_byte,
	input wire ccsd_pkg::ccsd_rx_info_s rx_info,
	output logic config_reset,
	output logic [2:0] transmit_request_set,
	output logic [1:0] receive_pending_clear
);
	import ccsd_pkg::*;

	typedef struct packed {
		ccsd_state_e state;
		ccsd_byte_t op;
		ccsd_byte_t ptr;
		ccsd_byte_t mask;
		logic fast;
		logic fast_buf;
		logic stat_rx;
		logic load_pend;
		logic cs_q;
		ccsd_reg_req_s req;
		logic cfg_rst;
		logic [2:0] rts;
		logic [1:0] rx_clr;
	} ccsd_core_s;

	ccsd_core_s s;
	ccsd_core_s next_s;
	ccsd_byte_t rx_byte;
	logic byte_done;
	logic sck_fall;
	logic tx_load;
	ccsd_byte_t tx_data;

	// serial input framing
	ccsd_spi_rx u_rx (
		.clk(clk),
		.rst(rst),
		.sck(sck),
		.cs_n(cs_n),
		.si(si),
		.rx_byte(rx_byte),
		.byte_done(byte_done),
		.sck_fall(sck_fall)
	);

	// byte source for the output shifter, loaded in the same cycle the pointer settles
	always_comb begin
		tx_load = s.load_pend && !cs_n;
		if (s.state == ST_STAT) begin
			tx_data = s.stat_rx ? rx_status_byte(rx_info) : read_status_byte;
		end else begin
			tx_data = reg_rd_data;
		end
	end

	// serial output
	ccsd_spi_tx u_tx (
		.clk(clk),
		.rst(rst),
		.cs_n(cs_n),
		.sck_fall(sck_fall),
		.load(tx_load),
		.ld_data(tx_data),
		.so(so),
		.so_oe(so_oe)
	);

	// command sequencer; one-cycle strobes fall back to zero every cycle
	always_comb begin
		next_s = s;
		next_s.cs_q = cs_n;
		next_s.req.wr = 1'b0;
		next_s.cfg_rst = 1'b0;
		next_s.rts = 3'h0;
		next_s.rx_clr = 2'h0;
		next_s.load_pend = 1'b0;
		if (cs_n) begin
			if (!s.cs_q && s.fast) begin
				next_s.rx_clr[s.fast_buf] = 1'b1;
			end
			next_s.state = ST_IDLE;
			next_s.fast = 1'b0;
		end else if (byte_done) begin
			unique case (s.state)
				ST_IDLE: begin
					next_s.op = rx_byte;
					next_s.state = ST_IGNORE;
					if (rx_byte == OP_RESET) begin
						next_s.cfg_rst = 1'b1;
					end else if (rx_byte == OP_READ || rx_byte == OP_WRITE || rx_byte == OP_MODIFY) begin
						next_s.state = ST_ADDR;
					end else if ((rx_byte & OP_FAST_RD_MASK) == OP_FAST_RD) begin
						next_s.ptr = fast_rd_addr(rx_byte[2], rx_byte[1]);
						next_s.req.addr = next_s.ptr;
						next_s.fast = 1'b1;
						next_s.fast_buf = rx_byte[2];
						next_s.load_pend = 1'b1;
						next_s.state = ST_RD;
					end else if ((rx_byte & OP_LOAD_TX_MASK) == OP_LOAD_TX) begin
						if (rx_byte[2:1] != TX_SEL_BAD) begin
							next_s.ptr = load_tx_addr(rx_byte[2:1], rx_byte[0]);
							next_s.state = ST_WR;
						end
					end else if ((rx_byte & OP_RTS_MASK) == OP_RTS) begin
						next_s.rts = rx_byte[2:0];
					end else if (rx_byte == OP_RD_STATUS || rx_byte == OP_RX_STATUS) begin
						next_s.stat_rx = (rx_byte == OP_RX_STATUS);
						next_s.load_pend = 1'b1;
						next_s.state = ST_STAT;
					end
				end
				ST_ADDR: begin
					next_s.ptr = rx_byte;
					if (s.op == OP_READ) begin
						next_s.req.addr = rx_byte;
						next_s.load_pend = 1'b1;
						next_s.state = ST_RD;
					end else if (s.op == OP_WRITE) begin
						next_s.state = ST_WR;
					end else begin
						next_s.state = ST_BM_MASK;
					end
				end
				ST_RD: begin
					next_s.ptr = 8'(s.ptr + PTR_STEP);
					next_s.req.addr = next_s.ptr;
					next_s.load_pend = 1'b1;
				end
				ST_WR: begin
					next_s.req.addr = s.ptr;
					next_s.req.wdata = rx_byte;
					next_s.req.wmask = MASK_ALL;
					next_s.req.wr = 1'b1;
					next_s.ptr = 8'(s.ptr + PTR_STEP);
				end
				ST_BM_MASK: begin
					next_s.mask = rx_byte;
					next_s.state = ST_BM_DATA;
				end
				ST_BM_DATA: begin
					next_s.req.addr = s.ptr;
					next_s.req.wdata = rx_byte;
					next_s.req.wmask = bm_capable(s.ptr) ? s.mask : MASK_ALL;
					next_s.req.wr = 1'b1;
					next_s.state = ST_IGNORE;
				end
				ST_STAT: begin
					next_s.load_pend = 1'b1;
				end
				ST_IGNORE: begin
					next_s.state = ST_IGNORE;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '{state: ST_IDLE, cs_q: 1'b1, req: '{wmask: MASK_ALL, default: '0}, default: '0};
		end else begin
			s <= next_s;
		end
	end

	assign reg_req = s.req;
	assign config_reset = s.cfg_rst;
	assign transmit_request_set = s.rts;
	assign receive_pending_clear = s.rx_clr;

	// checks on the sequencer
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	logic cmd_here;
	assign cmd_here = byte_done && !cs_n && (s.state == ST_IDLE);

	property p_reset_cmd;
		cmd_here && (rx_byte == OP_RESET) |=> config_reset ##1 !config_reset;
	endproperty
	a_reset_cmd: assert property (p_reset_cmd) else $error("reset opcode gave no single reset pulse");

	property p_read_addr;
		byte_done && !cs_n && (s.state == ST_ADDR) && (s.op == OP_READ) |=> (reg_req.addr == $past(rx_byte)) && tx_load;
	endproperty
	a_read_addr: assert property (p_read_addr) else $error("read did not start at the sent address");

	property p_fast_addr;
		cmd_here && ((rx_byte & OP_FAST_RD_MASK) == OP_FAST_RD)
			|=> (reg_req.addr == fast_rd_addr($past(rx_byte[2]), $past(rx_byte[1]))) && (s.state == ST_RD);
	endproperty
	a_fast_addr: assert property (p_fast_addr) else $error("fast receive read at wrong location");

	property p_fast_clear;
		s.fast && !s.cs_q && cs_n |=> receive_pending_clear == (2'h1 << $past(s.fast_buf));
	endproperty
	a_fast_clear: assert property (p_fast_clear) else $error("pending flag not cleared at deselect");

	property p_wr_commit;
		byte_done && !cs_n && (s.state == ST_WR)
			|=> reg_req.wr && (reg_req.wdata == $past(rx_byte)) && (reg_req.addr == $past(s.ptr)) && (s.ptr == 8'($past(s.ptr) + PTR_STEP));
	endproperty
	a_wr_commit: assert property (p_wr_commit) else $error("write byte not committed to next address");

	property p_wr_cause;
		reg_req.wr |-> $past(byte_done) && !$past(cs_n);
	endproperty
	a_wr_cause: assert property (p_wr_cause) else $error("write without a complete byte");

	property p_rts;
		cmd_here && ((rx_byte & OP_RTS_MASK) == OP_RTS) |=> (transmit_request_set == $past(rx_byte[2:0])) ##1 (transmit_request_set == 3'h0);
	endproperty
	a_rts: assert property (p_rts) else $error("transmit requests do not match command");

	property p_rts_cause;
		(transmit_request_set != 3'h0) |-> $past(cmd_here);
	endproperty
	a_rts_cause: assert property (p_rts_cause) else $error("transmit request without command");

	property p_stat_repeat;
		byte_done && !cs_n && (s.state == ST_STAT) |=> tx_load && (tx_data == $past(tx_data));
	endproperty
	a_stat_repeat: assert property (p_stat_repeat) else $error("status byte not repeated");

	property p_bm_mask;
		byte_done && !cs_n && (s.state == ST_BM_DATA)
			|=> reg_req.wr && (reg_req.wmask == (bm_capable($past(s.ptr)) ? $past(s.mask) : MASK_ALL));
	endproperty
	a_bm_mask: assert property (p_bm_mask) else $error("modify mask wrong");

	property p_rd_step;
		byte_done && !cs_n && (s.state == ST_RD) |=> (reg_req.addr == 8'($past(reg_req.addr) + PTR_STEP)) && tx_load;
	endproperty
	a_rd_step: assert property (p_rd_step) else $error("read pointer did not advance");

	property p_ignore;
		(s.state == ST_IGNORE) |=> !reg_req.wr && (transmit_request_set == 3'h0) && !config_reset;
	endproperty
	a_ignore: assert property (p_ignore) else $error("ignored command had an effect");

	property p_deselect;
		cs_n |=> (s.state == ST_IDLE) && !s.fast;
	endproperty
	a_deselect: assert property (p_deselect) else $error("decoder not idle after deselect");

	// output bit only moves one clk after a detected sck fall
	property p_so_edge;
		!cs_n && !$past(cs_n) && $changed(so) |-> $past(sck_fall);
	endproperty
	a_so_edge: assert property (p_so_edge) else $error("serial output changed without a falling sck");

	// fast transmit load places the pointer without an address byte
	property p_load_addr;
		cmd_here && ((rx_byte & OP_LOAD_TX_MASK) == OP_LOAD_TX) && (rx_byte[2:1] != TX_SEL_BAD)
			|=> (s.ptr == load_tx_addr($past(rx_byte[2:1]), $past(rx_byte[0]))) && (s.state == ST_WR);
	endproperty
	a_load_addr: assert property (p_load_addr) else $error("fast transmit load at wrong location");

	c_write_burst: cover property (reg_req.wr ##[1:300] reg_req.wr);
	c_fast_clear: cover property (receive_pending_clear != 2'h0);
	c_modify_masked: cover property (reg_req.wr && (reg_req.wmask != MASK_ALL));
	c_stat_second: cover property ((s.state == ST_STAT) && byte_done ##[1:300] (s.state == ST_STAT) && byte_done);
	c_select_sck_high: cover property ($fell(cs_n) && sck);
endmodule // ccsd_spi_cmd_decoder

// *** verif/ccsd_host.sv ***
// spi master model standing in for the host microcontroller
`timescale 1ns/100ps
module ccsd_host (
	input wire logic clk,
	input wire logic so,
	input wire logic so_oe,
	output logic sck,
	output logic cs_n,
	output logic si
);
	localparam int HALF = 6; // sck half period in clk cycles, above the decoder minimum
	logic idle = 1'b0; // sck level between frames, high for mode 1,1
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask
	// every command gets its own fresh select
	task automatic sel();
		sck <= idle;
		wait_clk(2);
		cs_n <= 1'b0;
		wait_clk(HALF);
	endtask
	// sck back to its idle level, then release; si flips so no stale bit lingers
	task automatic desel();
		sck <= idle;
		wait_clk(HALF);
		cs_n <= 1'b1;
		si <= ~si;
		wait_clk(5);
	endtask
	// msb first: si set with sck low, so read just before sck rises
	task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - nb; i--) begin
			sck <= 1'b0;
			si <= tx[i];
			wait_clk(HALF);
			rx[i] = so_oe ? so : 1'bx;
			sck <= 1'b1;
			wait_clk(HALF);
		end
	endtask
endmodule // ccsd_host

// *** verif/tb_top.sv ***
// self-checking bench for the spi command decoder
`timescale 1ns/100ps
module tb_top;
	import ccsd_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sck, cs_n, si, so, so_oe, config_reset;
	ccsd_reg_req_s reg_req;
	ccsd_byte_t reg_rd_data;
	ccsd_byte_t read_status_byte = 8'h00;
	ccsd_rx_info_s rx_info = '0;
	logic [2:0] transmit_request_set;
	logic [1:0] receive_pending_clear;
	ccsd_byte_t regs [256];
	ccsd_byte_t rx_adr [4] = '{RX0_ID_ADDR, RX0_DATA_ADDR, RX1_ID_ADDR, RX1_DATA_ADDR};
	ccsd_byte_t tx_adr [3] = '{TX0_ID_ADDR, TX1_ID_ADDR, TX2_ID_ADDR};
	int fail_count = 0;
	int checks_done = 0;
	int cr_cnt = 0;
	int wr_cnt = 0;
	logic [2:0] trs_acc = 3'h0;
	logic [1:0] rpc_acc = 2'h0;

	initial begin
		forever #2 clk = ~clk;
	end

	ccsd_spi_cmd_decoder ccsd_spi_cmd_decoder_inst (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
		.so(so), .so_oe(so_oe), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
		.read_status_byte(read_status_byte), .rx_info(rx_info), .config_reset(config_reset),
		.transmit_request_set(transmit_request_set), .receive_pending_clear(receive_pending_clear));
	ccsd_host ccsd_host_inst (.clk(clk), .so(so), .so_oe(so_oe), .sck(sck), .cs_n(cs_n), .si(si));

	// register file model and pulse collectors
	assign reg_rd_data = regs[reg_req.addr];
	always @(posedge clk) begin
		if (reg_req.wr === 1'b1) begin
			regs[reg_req.addr] <= (regs[reg_req.addr] & ~reg_req.wmask) | (reg_req.wdata & reg_req.wmask);
			wr_cnt++;
		end
		if (config_reset === 1'b1) cr_cnt++;
		trs_acc = trs_acc | transmit_request_set;
		rpc_acc = rpc_acc | receive_pending_clear;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
		ccsd_host_inst.xfer(tx, 8, rx);
	endtask

	// sequential write, immediate commit, partial last byte dropped
	task automatic t_write();
		logic [7:0] r;
		regs[8'h23] = 8'h11;
		ccsd_host_inst.sel();
		xb(OP_WRITE, r);
		xb(8'h20, r);
		xb(8'hA5, r);
		chk(regs[8'h20], 8'hA5, "first byte");
		xb(8'h5A, r);
		xb(8'h3C, r);
		ccsd_host_inst.xfer(8'hFF, 4, r);
		ccsd_host_inst.desel();
		chk(regs[8'h21], 8'h5A, "second byte");
		chk(regs[8'h22], 8'h3C, "third byte");
		chk(regs[8'h23], 8'h11, "partial byte");
		$display("test write done");
	endtask

	// read streams consecutive registers
	task automatic t_read();
		logic [7:0] r;
		for (int i = 0; i < 3; i++) regs[8'h40 + i] = 8'hC3 ^ 8'(i * 8'h35);
		ccsd_host_inst.sel();
		xb(OP_READ, r);
		xb(8'h40, r);
		for (int i = 0; i < 3; i++) begin
			xb(8'h00, r);
			chk(r, 8'hC3 ^ 8'(i * 8'h35), "read data");
		end
		ccsd_host_inst.desel();
		$display("test read done");
	endtask

	// mode 1,1: clock idles high around the frame
	task automatic t_mode11();
		logic [7:0] r;
		ccsd_host_inst.idle = 1'b1;
		ccsd_host_inst.sel();
		xb(OP_READ, r);
		xb(8'h40, r);
		for (int i = 0; i < 2; i++) begin
			xb(8'h00, r);
			chk(r, 8'hC3 ^ 8'(i * 8'h35), "mode 11 read");
		end
		ccsd_host_inst.desel();
		ccsd_host_inst.idle = 1'b0;
		$display("test mode 11 done");
	endtask

	// fast receive read of all four places, flag clear at release
	task automatic t_fast_rd();
		logic [7:0] r;
		for (int k = 0; k < 4; k++) begin
			regs[rx_adr[k]] = 8'h10 + 8'(k);
			regs[rx_adr[k] + 8'h01] = 8'h20 + 8'(k);
			rpc_acc = 2'h0;
			ccsd_host_inst.sel();
			xb(OP_FAST_RD | {5'h00, 2'(k), 1'b0}, r);
			xb(8'h00, r);
			chk(r, 8'h10 + 8'(k), "fast read first");
			xb(8'h00, r);
			chk(r, 8'h20 + 8'(k), "fast read next");
			ccsd_host_inst.desel();
			chk({6'h00, rpc_acc}, (k > 1) ? 8'h02 : 8'h01, "pending clear");
		end
		$display("test fast read done");
	endtask

	// fast transmit load of all six places, selector 11 refused
	task automatic t_load_tx();
		logic [7:0] r;
		int w0;
		for (int k = 0; k < 7; k++) begin
			w0 = wr_cnt;
			ccsd_host_inst.sel();
			xb(OP_LOAD_TX | 8'(k), r);
			xb(8'hE0 + 8'(k), r);
			ccsd_host_inst.desel();
			if (k < 6) chk(regs[tx_adr[k / 2] + ((k % 2) ? TX_DATA_OFS : 8'h00)], 8'hE0 + 8'(k), "load");
			else chk(8'(wr_cnt - w0), 8'h00, "bad selector");
		end
		$display("test load tx done");
	endtask

	// every request-to-send pattern, including none
	task automatic t_rts();
		logic [7:0] r;
		for (int n = 0; n < 8; n++) begin
			trs_acc = 3'h0;
			ccsd_host_inst.sel();
			xb(OP_RTS | 8'(n), r);
			ccsd_host_inst.desel();
			chk({5'h00, trs_acc}, 8'(n), "request set");
		end
		$display("test rts done");
	endtask

	// status bytes repeat while clocks continue
	task automatic t_status();
		logic [7:0] r;
		read_status_byte <= 8'hA7;
		ccsd_host_inst.sel();
		xb(OP_RD_STATUS, r);
		for (int i = 0; i < 2; i++) begin
			xb(8'h00, r);
			chk(r, 8'hA7, "read status");
		end
		ccsd_host_inst.desel();
		for (int k = 0; k < 2; k++) begin
			rx_info <= k ? ccsd_rx_info_s'{2'b01, 1'b0, 1'b1, 3'h6} : ccsd_rx_info_s'{2'b10, 1'b1, 1'b0, 3'h5};
			ccsd_host_inst.sel();
			xb(OP_RX_STATUS, r);
			for (int i = 0; i < 2; i++) begin
				xb(8'h00, r);
				chk(r, k ? 8'h4E : 8'h95, "rx status");
			end
			ccsd_host_inst.desel();
		end
		$display("test status done");
	endtask

	// masked update and forced full write
	task automatic t_modify();
		logic [7:0] r;
		regs[8'h2C] = 8'hF0;
		regs[8'h22] = 8'h00;
		for (int k = 0; k < 2; k++) begin
			ccsd_host_inst.sel();
			xb(OP_MODIFY, r);
			xb(k ? 8'h22 : 8'h2C, r);
			xb(8'h0F, r);
			xb(8'h5A, r);
			ccsd_host_inst.desel();
		end
		chk(regs[8'h2C], 8'hFA, "masked");
		chk(regs[8'h22], 8'h5A, "forced mask");
		$display("test modify done");
	endtask

	// reset command, then an unknown opcode that must change nothing
	task automatic t_reset_unknown();
		logic [7:0] r;
		int w0;
		cr_cnt = 0;
		trs_acc = 3'h0;
		ccsd_host_inst.sel();
		xb(OP_RESET, r);
		ccsd_host_inst.desel();
		chk(8'(cr_cnt), 8'h01, "reset pulse");
		w0 = wr_cnt;
		ccsd_host_inst.sel();
		xb(8'hFF, r);
		xb(8'h20, r);
		xb(8'h00, r);
		ccsd_host_inst.desel();
		chk(8'(wr_cnt - w0), 8'h00, "unknown writes");
		chk({4'h0, trs_acc, 1'(cr_cnt - 1)}, 8'h00, "unknown pulses");
		chk({7'h00, so_oe}, 8'h00, "released");
		$display("test reset and unknown done");
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// watchdog well beyond the expected run of some 7200 cycles
	initial begin
		repeat (60000) @(posedge clk);
		fail_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		close_out();
	end

	// main sequence
	initial begin
		for (int i = 0; i < 256; i++) regs[i] = 8'(i);
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_write();
		t_read();
		t_mode11();
		t_fast_rd();
		t_load_tx();
		t_rts();
		t_status();
		t_modify();
		t_reset_unknown();
		close_out();
	end
endmodule // tb_top
